// ===== gcw_pkg.sv
// shared constants, modes and carrier types for the control word decoder
package gcw_pkg;

  // data area byte offsets, most significant byte at the lower address
  localparam logic [9:0] GCW_STAT_HI_OFS = 10'h000;
  localparam logic [9:0] GCW_STAT_LO_OFS = 10'h001;
  localparam logic [9:0] GCW_CTRL_HI_OFS = 10'h200;
  localparam logic [9:0] GCW_CTRL_LO_OFS = 10'h201;

  // control word field positions
  localparam int GCW_HOST_CONFIRM_BIT = 15;
  localparam int GCW_HOST_SEND_BIT = 14;
  localparam int GCW_DATA_VALID_BIT = 13;
  localparam int GCW_EXEC_BIT = 12;
  localparam int GCW_CODE_MSB = 11;
  localparam int GCW_CODE_LSB = 8;
  localparam int GCW_ARG_MSB = 7;
  localparam int GCW_ARG_LSB = 0;

  // status word field positions
  localparam int GCW_GW_SEND_BIT = 15;
  localparam int GCW_GW_CONFIRM_BIT = 14;
  localparam int GCW_STAT_VALID_BIT = 13;
  localparam int GCW_STAT_CODE_MSB = 12;
  localparam int GCW_STAT_CODE_LSB = 8;

  // reset values
  localparam logic [15:0] GCW_CTRL_RESET = 16'h0000;
  localparam logic [7:0] GCW_RD_RESET = 8'h00;

  // node commands, master modes only
  localparam logic [3:0] GCW_CMD_DISABLE_NODE = 4'h0;
  localparam logic [3:0] GCW_CMD_ENABLE_NODE = 4'h1;
  localparam logic [3:0] GCW_CMD_ENABLE_NODES = 4'h2;

  // subnetwork node table size
  localparam int GCW_NODE_COUNT = 256;

  // initialization mailbox layout limits, kept by the configuration side
  localparam int GCW_MBX_HDR_WORDS = 16;
  localparam int GCW_MBX_HDR_BYTES = 32;
  localparam int GCW_MBX_DATA_MAX_WORDS = 128;
  localparam int GCW_MBX_DATA_MAX_BYTES = 256;
  localparam logic [15:0] GCW_MBX_MSG_INFO = 16'h4002;

  // operating modes, one-hot
  typedef enum logic [2:0] {
    GCW_MODE_GENERIC = 3'h1,
    GCW_MODE_MASTER = 3'h2,
    GCW_MODE_ALT_SERIAL_MASTER = 3'h4
  } gcw_mode_t;

  // one decoded command
  typedef struct packed {
    logic [3:0] code;
    logic [7:0] arg;
  } gcw_cmd_t;

  // status fields supplied by the gateway core
  typedef struct packed {
    logic data_valid;
    logic [4:0] code;
    logic [7:0] data;
  } gcw_status_t;

endpackage

// ===== gcw_node_table.sv
// per-node enable table driven by decoded node commands
module gcw_node_table
  import gcw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // command strobe
  input wire logic cmd_valid_i,
  input wire gcw_cmd_t cmd_i,
  // configured node range
  input wire logic [7:0] cfg_first_i,
  input wire logic [8:0] cfg_count_i,
  // per-node enables
  output logic [GCW_NODE_COUNT-1:0] node_en_o
);

  // one enable flop per node address
  for (genvar i = 0; i < GCW_NODE_COUNT; i++) begin : g_node
    logic [7:0] rank;
    logic configured;
    logic addr_hit;
    logic bulk_on;
    assign rank = 8'(i) - cfg_first_i;       // position within the configuration
    assign configured = {1'b0, rank} < cfg_count_i;
    assign addr_hit = cmd_i.arg == 8'(i);
    assign bulk_on = configured && ({1'b0, rank} < {1'b0, cmd_i.arg});

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        node_en_o[i] <= 1'b1;
      end else if (cmd_valid_i) begin
        case (cmd_i.code)
          GCW_CMD_DISABLE_NODE: if (addr_hit) node_en_o[i] <= 1'b0;
          GCW_CMD_ENABLE_NODE: if (addr_hit) node_en_o[i] <= 1'b1;
          GCW_CMD_ENABLE_NODES: node_en_o[i] <= bulk_on;
          default: node_en_o[i] <= node_en_o[i];
        endcase
      end
    end
  end

endmodule

// ===== gcw_ctrl_word_decoder.sv
// control word decoder: data area access, handshake, data valid and node commands

module gcw_ctrl_word_decoder
  import gcw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // configuration
  input wire logic ctrl_status_en_i,
  input wire gcw_mode_t mode_i,
  input wire logic [7:0] cfg_first_node_i,
  input wire logic [8:0] cfg_node_count_i,
  // data area write port from the control system
  input wire logic area_wr_i,
  input wire logic [9:0] area_waddr_i,
  input wire logic [7:0] area_wdata_i,
  // data area read port to the control system
  input wire logic area_rd_i,
  input wire logic [9:0] area_raddr_i,
  output logic [7:0] area_rdata_o,
  output logic area_rvalid_o,
  // gateway core status and input data side
  input wire gcw_status_t gw_status_i,
  input wire logic in_data_ready_i,
  output logic in_busy_o,
  output logic in_acked_o,
  // output data side
  output logic out_data_new_o,
  output logic exchange_en_o,
  // command results
  output logic cmd_done_o,
  output logic cmd_reject_o,
  output logic [GCW_NODE_COUNT-1:0] node_en_o,
  // control word as held
  output logic [15:0] host_ctrl_o
);

  // timing overview for users of this block:
  // - a byte written to the control word lands in host_ctrl_o one edge later
  // - commands, handshake and exchange gating all act on the held word, so
  //   every reaction starts one edge after the byte that caused it landed
  // - result strobes and the node table move on the same edge, two edges
  //   after the write of the byte that carries the execute bit
  // - reads answer one edge after the strobe; read data is zero otherwise,
  //   so a host that samples outside rvalid sees a harmless zero byte
  // - with the control and status words disabled, the word is frozen, no
  //   command can fire and exchange stays allowed

  // state
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic gw_send_q;
  logic gw_confirm_q;
  logic host_send_seen_q;
  logic host_confirm_seen_q;
  logic exec_armed_q;
  logic [7:0] area_rdata_q;
  logic [7:0] area_rdata_d;
  logic area_rvalid_q;
  logic exchange_en_q;
  logic exchange_en_d;
  logic out_data_new_q;
  logic in_acked_q;
  logic in_busy_q;
  logic cmd_done_q;
  logic cmd_reject_q;

  // control word fields
  logic host_confirm_flag;
  logic host_send_flag;
  logic data_valid_flag;
  logic exec_flag;
  gcw_cmd_t cmd_field;

  // decode
  logic wr_ctrl_hi;
  logic wr_ctrl_lo;
  logic rd_stat_hi;
  logic rd_stat_lo;
  logic rd_ctrl_hi;
  logic rd_ctrl_lo;
  logic [15:0] status_word;
  logic master_mode;
  logic code_known;
  logic exec_rise;
  logic cmd_fire;
  logic cmd_refuse;
  logic host_send_toggled;
  logic host_confirm_match;
  logic in_take;

  // field split of the held control word
  assign host_confirm_flag = ctrl_q[GCW_HOST_CONFIRM_BIT];
  assign host_send_flag = ctrl_q[GCW_HOST_SEND_BIT];
  assign data_valid_flag = ctrl_q[GCW_DATA_VALID_BIT];
  assign exec_flag = ctrl_q[GCW_EXEC_BIT];
  assign cmd_field.code = ctrl_q[GCW_CODE_MSB:GCW_CODE_LSB];
  assign cmd_field.arg = ctrl_q[GCW_ARG_MSB:GCW_ARG_LSB];

  // data area write decode, control word bytes only when enabled
  assign wr_ctrl_hi = area_wr_i && ctrl_status_en_i && (area_waddr_i == GCW_CTRL_HI_OFS);
  assign wr_ctrl_lo = area_wr_i && ctrl_status_en_i && (area_waddr_i == GCW_CTRL_LO_OFS);

  // data area read decode
  assign rd_stat_hi = area_rd_i && ctrl_status_en_i && (area_raddr_i == GCW_STAT_HI_OFS);
  assign rd_stat_lo = area_rd_i && ctrl_status_en_i && (area_raddr_i == GCW_STAT_LO_OFS);
  assign rd_ctrl_hi = area_rd_i && ctrl_status_en_i && (area_raddr_i == GCW_CTRL_HI_OFS);
  assign rd_ctrl_lo = area_rd_i && ctrl_status_en_i && (area_raddr_i == GCW_CTRL_LO_OFS);

  // byte merge: the lower address carries the upper byte
  // each byte lands on its own, so the host must write the argument byte
  // before the byte that holds the code and the execute bit; otherwise a command
  // would fire with a stale argument from the previous command
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl_hi) begin
      ctrl_d[15:8] = area_wdata_i;
    end
    if (wr_ctrl_lo) begin
      ctrl_d[7:0] = area_wdata_i;
    end
  end

  // status word assembled from handshake flops and core status
  assign status_word[GCW_GW_SEND_BIT] = gw_send_q;
  assign status_word[GCW_GW_CONFIRM_BIT] = gw_confirm_q;
  assign status_word[GCW_STAT_VALID_BIT] = gw_status_i.data_valid;
  assign status_word[GCW_STAT_CODE_MSB:GCW_STAT_CODE_LSB] = gw_status_i.code;
  assign status_word[7:0] = gw_status_i.data;

  // read data select, unmapped or disabled reads return zero
  always_comb begin
    area_rdata_d = GCW_RD_RESET;
    if (rd_stat_hi) begin
      area_rdata_d = status_word[15:8];
    end else if (rd_stat_lo) begin
      area_rdata_d = status_word[7:0];
    end else if (rd_ctrl_hi) begin
      area_rdata_d = ctrl_q[15:8];
    end else if (rd_ctrl_lo) begin
      area_rdata_d = ctrl_q[7:0];
    end
  end

  // mode decode; an illegal mode code counts as no master mode
  always_comb begin
    unique case (mode_i)
      GCW_MODE_GENERIC: master_mode = 1'b0;
      GCW_MODE_MASTER: master_mode = 1'b1;
      GCW_MODE_ALT_SERIAL_MASTER: master_mode = 1'b1;
      default: master_mode = 1'b0;
    endcase
  end

  // command qualification
  // an execute seen in generic mode, in an illegal mode or with an unknown
  // code still disarms the execute bit and answers with a reject strobe;
  // this keeps one answer per execute whatever the code, so the host can
  // always wait for exactly one strobe before clearing the execute bit
  assign code_known = (cmd_field.code == GCW_CMD_DISABLE_NODE) ||
                      (cmd_field.code == GCW_CMD_ENABLE_NODE) ||
                      (cmd_field.code == GCW_CMD_ENABLE_NODES);
  assign exec_rise = ctrl_status_en_i && exec_flag && exec_armed_q;
  assign cmd_fire = exec_rise && master_mode && code_known;
  assign cmd_refuse = exec_rise && !(master_mode && code_known);

  // the handshake is toggle based in both directions: a flag carries news
  // when it differs from what was seen before, never by its level alone;
  // the seen copies start at zero, matching the cleared word after reset,
  // so no false toggle follows a reset
  // handshake towards the gateway: a host send toggle flags new output data
  assign host_send_toggled = ctrl_status_en_i && (host_send_flag != host_send_seen_q);
  // handshake towards the host: host confirm equal to gateway send closes a transfer
  assign host_confirm_match = ctrl_status_en_i && (host_confirm_flag != host_confirm_seen_q)
                              && (host_confirm_flag == gw_send_q);
  // new input data is only announced while no earlier announcement is pending
  assign in_take = ctrl_status_en_i && in_data_ready_i && (gw_send_q == host_confirm_flag);

  // exchange gating: valid bit only steers when control/status is enabled
  assign exchange_en_d = ctrl_status_en_i ? data_valid_flag : 1'b1;

  // control word register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= GCW_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // execute arming: rearmed only once the execute bit has been seen low
  // armed at reset, so a word written with execute already set right after
  // reset still runs its command once
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exec_armed_q <= 1'b1;
    end else if (!exec_flag) begin
      exec_armed_q <= 1'b1;
    end else if (exec_rise) begin
      exec_armed_q <= 1'b0;
    end
  end

  // gateway-side handshake flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gw_send_q <= 1'b0;
      gw_confirm_q <= 1'b0;
      host_send_seen_q <= 1'b0;
      host_confirm_seen_q <= 1'b0;
    end else begin
      host_send_seen_q <= host_send_flag;
      host_confirm_seen_q <= host_confirm_flag;
      if (host_send_toggled) begin
        gw_confirm_q <= host_send_flag;
      end
      if (in_take) begin
        gw_send_q <= !gw_send_q;
      end
    end
  end

  // handshake and exchange outputs
  // busy looks ahead by one take so that it rises on the same edge as the
  // gateway send flag; out_data_new only pulses while exchange is allowed,
  // so output data marked invalid is never handed to the subnetwork
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_data_new_q <= 1'b0;
      in_acked_q <= 1'b0;
      in_busy_q <= 1'b0;
      exchange_en_q <= 1'b0;
    end else begin
      out_data_new_q <= host_send_toggled && exchange_en_d;
      in_acked_q <= host_confirm_match;
      in_busy_q <= (gw_send_q ^ in_take) != host_confirm_flag;
      exchange_en_q <= exchange_en_d;
    end
  end

  // command result strobes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_done_q <= 1'b0;
      cmd_reject_q <= 1'b0;
    end else begin
      cmd_done_q <= cmd_fire;
      cmd_reject_q <= cmd_refuse;
    end
  end

  // read port
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      area_rdata_q <= GCW_RD_RESET;
      area_rvalid_q <= 1'b0;
    end else begin
      area_rdata_q <= area_rdata_d;
      area_rvalid_q <= area_rd_i;
    end
  end

  // node enable table, updated one cycle after a command fires
  // the table sees only qualified commands, so generic mode and unknown codes
  // leave every node enable untouched
  gcw_node_table u_node_table (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .cmd_valid_i(cmd_fire),
    .cmd_i(cmd_field),
    .cfg_first_i(cfg_first_node_i),
    .cfg_count_i(cfg_node_count_i),
    .node_en_o(node_en_o)
  );

  // output drive
  // every output below comes straight from a flip-flop of this block or of
  // the node table, so no decode path reaches the pins
  assign area_rdata_o = area_rdata_q;
  assign area_rvalid_o = area_rvalid_q;
  assign in_busy_o = in_busy_q;
  assign in_acked_o = in_acked_q;
  assign out_data_new_o = out_data_new_q;
  assign exchange_en_o = exchange_en_q;
  assign cmd_done_o = cmd_done_q;
  assign cmd_reject_o = cmd_reject_q;
  assign host_ctrl_o = ctrl_q;

endmodule

// ===== gcw_ctrl_properties.sv
// port assertions for the control word decoder
module gcw_ctrl_props
  import gcw_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // watched inputs
  input wire logic ctrl_status_en_i,
  input wire gcw_mode_t mode_i,
  input wire logic area_wr_i,
  input wire logic [9:0] area_waddr_i,
  input wire logic [7:0] area_wdata_i,
  input wire logic area_rd_i,
  input wire logic [9:0] area_raddr_i,
  input wire gcw_status_t gw_status_i,
  // watched outputs
  input wire logic [7:0] area_rdata_o,
  input wire logic area_rvalid_o,
  input wire logic exchange_en_o,
  input wire logic cmd_done_o,
  input wire logic cmd_reject_o,
  input wire logic [GCW_NODE_COUNT-1:0] node_en_o,
  input wire logic [15:0] host_ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // shorthands
  wire logic en = ctrl_status_en_i;
  wire logic wr_hi = en && area_wr_i && area_waddr_i == GCW_CTRL_HI_OFS;
  wire logic wr_lo = en && area_wr_i && area_waddr_i == GCW_CTRL_LO_OFS;
  property p_wr_hi;
    wr_hi |=> host_ctrl_o[15:8] == $past(area_wdata_i);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high byte lost");
  property p_wr_lo;
    wr_lo |=> host_ctrl_o[7:0] == $past(area_wdata_i);
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low byte lost");
  property p_off;
    !en |=> exchange_en_o;
  endproperty
  a_off: assert property (p_off) else $error("exchange blocked");
  property p_valid;
    en [*2] ##0 $stable(host_ctrl_o[13]) |-> exchange_en_o == host_ctrl_o[13];
  endproperty
  a_valid: assert property (p_valid) else $error("exchange mismatch");
  property p_dis;
    $rose(host_ctrl_o[12]) && en && mode_i == GCW_MODE_MASTER && host_ctrl_o[11:8] == 4'h0
      |=> cmd_done_o && !node_en_o[$past(host_ctrl_o[7:0])];
  endproperty
  a_dis: assert property (p_dis) else $error("node not disabled");
  property p_gen;
    $rose(host_ctrl_o[12]) && en && mode_i == GCW_MODE_GENERIC
      |=> cmd_reject_o && !cmd_done_o && $stable(node_en_o);
  endproperty
  a_gen: assert property (p_gen) else $error("generic command run");
  property p_once;
    (en && host_ctrl_o[12]) [*3] |-> !cmd_done_o && !cmd_reject_o;
  endproperty
  a_once: assert property (p_once) else $error("command repeated");
  property p_stat;
    en && area_rd_i && area_raddr_i == GCW_STAT_HI_OFS |=> area_rvalid_o
      && area_rdata_o[5:0] == {$past(gw_status_i.data_valid), $past(gw_status_i.code)};
  endproperty
  a_stat: assert property (p_stat) else $error("status byte wrong");
endmodule

// ===== gcw_host_model.sv
// control system model driving the data area port
module gcw_host
  import gcw_pkg::*;
(
  // clock
  input wire logic clk_i,
  // data area access
  output logic area_wr_o,
  output logic [9:0] area_waddr_o,
  output logic [7:0] area_wdata_o,
  output logic area_rd_o,
  output logic [9:0] area_raddr_o,
  input wire logic [7:0] area_rdata_i,
  input wire logic area_rvalid_i
);
  // start-up mailbox layout the host would build
  localparam int MBX_BYTES = 2 * (GCW_MBX_HDR_WORDS + GCW_MBX_DATA_MAX_WORDS);
  localparam logic [15:0] MBX_INFO = GCW_MBX_MSG_INFO;
  // idle port
  initial begin
    area_wr_o = 1'b0;
    area_rd_o = 1'b0;
    area_waddr_o = 10'h000;
    area_wdata_o = 8'h00;
    area_raddr_o = 10'h000;
  end
  // one byte write, lines toggled once released
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    area_wr_o <= 1'b1;
    area_waddr_o <= a;
    area_wdata_o <= d;
    @(posedge clk_i);
    area_wr_o <= 1'b0;
    area_waddr_o <= ~a;
    area_wdata_o <= ~d;
  endtask
  // one byte read, answer taken one edge after the read edge
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    area_rd_o <= 1'b1;
    area_raddr_o <= a;
    @(posedge clk_i);
    area_rd_o <= 1'b0;
    area_raddr_o <= ~a;
    @(posedge clk_i);
    d = area_rdata_i;
    v = area_rvalid_i;
  endtask
endmodule

// ===== gcw_ctrl_word_decoder_tb.sv
// self-checking bench for the control word decoder
module gcw_ctrl_word_decoder_tb
  import gcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic en = 1'b1;
  gcw_mode_t mode = GCW_MODE_MASTER;
  logic [7:0] first = 8'h0A;
  logic [8:0] count = 9'h008;
  gcw_status_t gst = '0;
  logic rdy = 1'b0;
  logic wr, rd, rv, busy, ack, onew, xen, done, rej;
  logic [9:0] wa, ra;
  logic [7:0] wd, rdat;
  logic [255:0] node;
  logic [15:0] hctl;
  int fail_count = 0;
  int total_checks = 0;
  int done_n = 0;
  int rej_n = 0;
  int ack_n = 0;
  int new_n = 0;
  gcw_host gcw_host_i (.clk_i, .area_wr_o(wr), .area_waddr_o(wa), .area_wdata_o(wd),
    .area_rd_o(rd), .area_raddr_o(ra), .area_rdata_i(rdat), .area_rvalid_i(rv));
  gcw_ctrl_word_decoder gcw_ctrl_word_decoder_i (.clk_i, .srst_i, .ctrl_status_en_i(en),
    .mode_i(mode), .cfg_first_node_i(first), .cfg_node_count_i(count), .area_wr_i(wr),
    .area_waddr_i(wa), .area_wdata_i(wd), .area_rd_i(rd), .area_raddr_i(ra),
    .area_rdata_o(rdat), .area_rvalid_o(rv), .gw_status_i(gst), .in_data_ready_i(rdy),
    .in_busy_o(busy), .in_acked_o(ack), .out_data_new_o(onew), .exchange_en_o(xen),
    .cmd_done_o(done), .cmd_reject_o(rej), .node_en_o(node), .host_ctrl_o(hctl));
  always #2 clk_i = ~clk_i;
  // pulse counters
  always @(posedge clk_i) begin
    if (!srst_i) begin
      done_n <= done_n + int'(done);
      rej_n <= rej_n + int'(rej);
      ack_n <= ack_n + int'(ack);
      new_n <= new_n + int'(onew);
    end
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    gcw_host_i.rd(a, d, v);
    chk({v, d}, {1'b1, e});
  endtask
  // argument first, then execute held a while, then cleared
  task automatic cmd(input logic [3:0] c, input logic [7:0] a);
    gcw_host_i.wr(GCW_CTRL_LO_OFS, a);
    gcw_host_i.wr(GCW_CTRL_HI_OFS, {4'h3, c});
    repeat (4) @(posedge clk_i);
    gcw_host_i.wr(GCW_CTRL_HI_OFS, 8'h20);
  endtask
  task automatic conclude();
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #40000;
    fail_count++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    chk(node, {256{1'b1}});
    rchk(GCW_CTRL_HI_OFS, 8'h00);
    gcw_host_i.wr(GCW_CTRL_LO_OFS, 8'hA5);
    gcw_host_i.wr(GCW_CTRL_HI_OFS, 8'h25);
    @(posedge clk_i);
    chk(hctl, 16'h25A5);
    rchk(GCW_CTRL_LO_OFS, 8'hA5);
    rchk(10'h123, 8'h00);
    chk(xen, 1'b1);
    gst <= {1'b1, 5'h1F, 8'h3C};
    rchk(GCW_STAT_LO_OFS, 8'h3C);
    // host send toggle answered by gateway confirm
    gcw_host_i.wr(GCW_CTRL_HI_OFS, 8'h65);
    rchk(GCW_STAT_HI_OFS, 8'h7F);
    chk(new_n, 1);
    // gateway announces data, second offer while pending is refused
    repeat (2) begin
      rdy <= 1'b1;
      @(posedge clk_i);
      rdy <= 1'b0;
      @(posedge clk_i);
    end
    chk(busy, 1'b1);
    rchk(GCW_STAT_HI_OFS, 8'hFF);
    gcw_host_i.wr(GCW_CTRL_HI_OFS, 8'hE5);
    repeat (3) @(posedge clk_i);
    chk({busy, 8'(ack_n)}, {1'b0, 8'h01});
    // node commands across modes
    cmd(GCW_CMD_DISABLE_NODE, 8'h05);
    chk(node, ~(256'h1 << 5));
    cmd(GCW_CMD_ENABLE_NODE, 8'h05);
    chk(node, {256{1'b1}});
    chk(done_n, 2);
    mode <= GCW_MODE_ALT_SERIAL_MASTER;
    cmd(GCW_CMD_ENABLE_NODES, 8'h03);
    chk(node, 256'h7 << 10);
    mode <= GCW_MODE_GENERIC;
    cmd(GCW_CMD_ENABLE_NODE, 8'h00);
    chk(node, 256'h7 << 10);
    chk({8'(rej_n), 8'(done_n)}, {8'h01, 8'h03});
    // unknown code in a master mode is refused and leaves the table alone
    mode <= GCW_MODE_MASTER;
    cmd(4'h7, 8'h00);
    chk({8'(rej_n), 8'(done_n), node[12:10]}, {8'h02, 8'h03, 3'h7});
    // words disabled: writes dropped, exchange always on
    en <= 1'b0;
    gcw_host_i.wr(GCW_CTRL_HI_OFS, 8'h00);
    @(posedge clk_i);
    chk({xen, hctl[15:8]}, {1'b1, 8'h20});
    en <= 1'b1;
    gcw_host_i.wr(GCW_CTRL_HI_OFS, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(xen, 1'b0);
    conclude();
  end
endmodule

bind gcw_ctrl_word_decoder gcw_ctrl_props gcw_ctrl_props_i (.clk_i, .srst_i,
  .ctrl_status_en_i, .mode_i, .area_wr_i, .area_waddr_i, .area_wdata_i, .area_rd_i,
  .area_raddr_i, .gw_status_i, .area_rdata_o, .area_rvalid_o, .exchange_en_o,
  .cmd_done_o, .cmd_reject_o, .node_en_o, .host_ctrl_o);
